// >>> rtl/vrs_pkg.sv
// Constants shared by the reference stepper and its code sampler
package vrs_pkg;
   localparam int CODE_W = 5;
   localparam int MV_W = 11;
   localparam logic [4:0] SHUTDOWN_CODE = 5'h1F;
   localparam logic [4:0] RESET_CODE = 5'h1F;
   localparam logic [4:0] RESET_INDEX = 5'h1E;
   localparam logic [10:0] TOP_MV = 11'h60E;
   localparam logic [10:0] STEP_MV = 11'h019;
   localparam logic [10:0] RESET_MV = 11'h320;
   typedef enum logic [1:0] {
      VRS_IDLE,
      VRS_WAIT,
      VRS_STEP
   } vrs_state_t;
endpackage

// >>> rtl/vrs_code_if.sv
// Carries accepted identification codes from sampler to stepper
`timescale 1ns/1ns
interface vrs_code_if;
   logic [4:0] code;
   logic accept;
   modport sampler (output code, output accept);
   modport stepper (input code, input accept);
endinterface

// >>> rtl/vrs_code_sampler.sv
// Synchronises the identification pins and qualifies code changes
`timescale 1ns/1ns
module vrs_code_sampler (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_cycle_start,
   input wire logic [4:0] i_voltage_id_code,
   vrs_code_if.sampler code_if
);
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic [4:0] sync3_r;
   logic [4:0] seen_r;
   logic [4:0] seen_nxt;
   logic pend_r;
   logic pend_nxt;
   logic [4:0] code_r;
   logic [4:0] code_nxt;
   logic accept_r;
   logic accept_nxt;

   always_comb
   begin
      seen_nxt = seen_r;
      pend_nxt = pend_r;
      code_nxt = code_r;
      accept_nxt = 1'b0;
      // Pins looked at only on a cycle boundary, and only when settled
      if (i_cycle_start && (sync2_r == sync3_r))
      begin
         if (sync3_r != seen_r)
         begin
            seen_nxt = sync3_r;
            pend_nxt = 1'b1;
         end
         else if (pend_r)
         begin
            // Unchanged across one more boundary: act on it
            pend_nxt = 1'b0;
            code_nxt = seen_r;
            accept_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         sync1_r <= vrs_pkg::RESET_CODE;
         sync2_r <= vrs_pkg::RESET_CODE;
         sync3_r <= vrs_pkg::RESET_CODE;
         seen_r <= vrs_pkg::RESET_CODE;
         pend_r <= 1'b0;
         code_r <= vrs_pkg::RESET_CODE;
         accept_r <= 1'b0;
      end
      else
      begin
         sync1_r <= i_voltage_id_code;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         seen_r <= seen_nxt;
         pend_r <= pend_nxt;
         code_r <= code_nxt;
         accept_r <= accept_nxt;
      end
   end

   assign code_if.code = code_r;
   assign code_if.accept = accept_r;
endmodule // vrs_code_sampler

// >>> rtl/vrs_reference_stepper.sv
// Identification-code driven reference stepper for a multi-phase buck
//
// Contract
// - Each code increment lowers target 25 mV
// - All-ones code shuts down, others restart
// - Inputs sampled only at switching-cycle start
// - New code acted on after staying stable
// - One 25 mV step every second cycle
// - Changes between boundaries ignored until next boundary
// - One-cycle wait before first step
// - Transition time bounded by step count formula
`timescale 1ns/1ns
module vrs_reference_stepper (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_cycle_start,
   input wire logic [4:0] i_voltage_id_code,
   output logic [4:0] o_ref_index,
   output logic [10:0] o_ref_mv,
   output logic [10:0] o_target_mv,
   output logic o_busy,
   output logic o_step_up,
   output logic o_step_down,
   output logic o_shutdown,
   output logic o_done
);
   // Codes arrive already qualified on cycle boundaries
   vrs_code_if code_if ();

   vrs_code_sampler u_sampler (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_cycle_start(i_cycle_start),
      .i_voltage_id_code(i_voltage_id_code),
      .code_if(code_if)
   );

   vrs_pkg::vrs_state_t state_r;
   vrs_pkg::vrs_state_t state_nxt;
   logic [4:0] ref_r;
   logic [4:0] ref_nxt;
   logic [4:0] target_r;
   logic [4:0] target_nxt;
   logic half_r;
   logic half_nxt;
   logic shutdown_r;
   logic shutdown_nxt;
   logic [10:0] ref_mv_r;
   logic [10:0] ref_mv_nxt;
   logic [10:0] target_mv_r;
   logic [10:0] target_mv_nxt;
   logic up_r;
   logic up_nxt;
   logic down_r;
   logic down_nxt;
   logic done_r;
   logic done_nxt;
   logic busy_r;
   logic busy_nxt;

   // Index counts 25 mV steps below the top of the range
   // Shutdown code never becomes an index, so no underflow
   function automatic logic [10:0] index_to_mv(input logic [4:0] idx);
      index_to_mv = 11'(vrs_pkg::TOP_MV - 11'(vrs_pkg::STEP_MV * idx));
   endfunction

   // Control group: state, indices, half-cycle flag, shutdown
   always_comb
   begin
      state_nxt = state_r;
      ref_nxt = ref_r;
      target_nxt = target_r;
      half_nxt = half_r;
      shutdown_nxt = shutdown_r;

      unique case (state_r)
         vrs_pkg::VRS_IDLE:
         begin
            // Holds until a code other than the current index and the shutdown code is accepted
         end
         vrs_pkg::VRS_WAIT:
         begin
            // Wait out the rest of the current switching cycle, up to the next boundary, before stepping
            if (i_cycle_start)
            begin
               state_nxt = vrs_pkg::VRS_STEP;
               half_nxt = 1'b0;
            end
         end
         vrs_pkg::VRS_STEP:
         begin
            if (i_cycle_start)
            begin
               half_nxt = !half_r;
               // Step lands on every second boundary
               if (half_r)
               begin
                  if (target_r > ref_r)
                  begin
                     ref_nxt = 5'(ref_r + 5'h01);
                  end
                  else if (target_r < ref_r)
                  begin
                     ref_nxt = 5'(ref_r - 5'h01);
                  end
                  if (ref_nxt == target_r)
                  begin
                     state_nxt = vrs_pkg::VRS_IDLE;
                  end
               end
            end
         end
      endcase

      // A newly accepted code other than the shutdown code overrides whatever stepping is under way
      if (code_if.accept)
      begin
         if (code_if.code == vrs_pkg::SHUTDOWN_CODE)
         begin
            // Target and state left as they are, so any stepping under way carries on
            shutdown_nxt = 1'b1;
         end
         else
         begin
            shutdown_nxt = 1'b0;
            target_nxt = code_if.code;
            if (code_if.code != ref_r)
            begin
               state_nxt = vrs_pkg::VRS_WAIT;
            end
            else
            begin
               state_nxt = vrs_pkg::VRS_IDLE;
            end
         end
      end

   end

   // Reset parks the reference at the bottom code, shut down
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         state_r <= vrs_pkg::VRS_IDLE;
         ref_r <= vrs_pkg::RESET_INDEX;
         target_r <= vrs_pkg::RESET_INDEX;
         half_r <= 1'b0;
         shutdown_r <= 1'b1;
      end
      else
      begin
         state_r <= state_nxt;
         ref_r <= ref_nxt;
         target_r <= target_nxt;
         half_r <= half_nxt;
         shutdown_r <= shutdown_nxt;
      end
   end

   // Pulses follow from which way the index moved this edge
   // Index down is voltage up, hence the crossed names
   always_comb
   begin
      up_nxt = (ref_nxt < ref_r);
      down_nxt = (ref_nxt > ref_r);
      // Landing judged against the target held before this edge
      done_nxt = (state_r == vrs_pkg::VRS_STEP) && i_cycle_start && half_r
         && (ref_nxt == target_r);
   end

   // Registered so the pulses leave straight from flops
   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         up_r <= 1'b0;
         down_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         up_r <= up_nxt;
         down_r <= down_nxt;
         done_r <= done_nxt;
      end
   end

   // Views recomputed from the next indices, so each changes on
   // the same edge as the index it describes
   always_comb
   begin
      busy_nxt = (state_nxt != vrs_pkg::VRS_IDLE);
      ref_mv_nxt = index_to_mv(ref_nxt);
      target_mv_nxt = index_to_mv(target_nxt);
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rstn)
      begin
         ref_mv_r <= vrs_pkg::RESET_MV;
         target_mv_r <= vrs_pkg::RESET_MV;
         busy_r <= 1'b0;
      end
      else
      begin
         ref_mv_r <= ref_mv_nxt;
         target_mv_r <= target_mv_nxt;
         busy_r <= busy_nxt;
      end
   end

   // Outputs leave straight from the registers above
   assign o_ref_index = ref_r;
   assign o_ref_mv = ref_mv_r;
   assign o_target_mv = target_mv_r;
   assign o_busy = busy_r;
   assign o_step_up = up_r;
   assign o_step_down = down_r;
   assign o_shutdown = shutdown_r;
   assign o_done = done_r;
endmodule // vrs_reference_stepper

// >>> tb/vrs_cpu_model.sv
// Processor model driving the identification code pins
`timescale 1ns/1ns
module vrs_cpu_model (
   input wire logic i_mclk,
   output logic [4:0] o_code
);
   initial o_code = 5'h1F;
   // Moves off the sampling edge, then holds until the next call
   task automatic put(input logic [4:0] c);
      @(negedge i_mclk);
      o_code = c;
   endtask
endmodule // vrs_cpu_model

// >>> tb/vrs_checker.sv
// Port assertions for the reference stepper
`timescale 1ns/1ns
module vrs_checker (
   input wire logic i_mclk,
   input wire logic i_rstn,
   input wire logic i_cycle_start,
   input wire logic [4:0] o_ref_index,
   input wire logic [10:0] o_ref_mv,
   input wire logic [10:0] o_target_mv,
   input wire logic o_busy,
   input wire logic o_step_up,
   input wire logic o_step_down,
   input wire logic o_shutdown,
   input wire logic o_done
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   wire stp = o_step_up | o_step_down;
   ref_decode_a: assert property (
      o_ref_mv == 11'h60E - 11'h019 * o_ref_index) else $error("bad mV");
   step_edge_a: assert property (
      stp |-> $past(i_cycle_start)) else $error("step off edge");
   step_size_a: assert property (
      $changed(o_ref_index) && $past(i_rstn) |->
      o_ref_index - $past(o_ref_index) inside {5'h01, 5'h1F})
      else $error("step size");
   done_hit_a: assert property (
      o_done |-> !o_busy ##[0:1] o_ref_mv == o_target_mv)
      else $error("done off target");
   shut_edge_a: assert property (
      $changed(o_shutdown) && $past(i_rstn) |-> $past(i_cycle_start, 2))
      else $error("shut off edge");
   tgt_edge_a: assert property (
      $changed(o_target_mv) && $past(i_rstn) |-> $past(i_cycle_start, 2))
      else $error("target off edge");
   first_wait_a: assert property (
      $rose(o_busy) |-> !stp [*3]) else $error("early step");
   step_dir_a: assert property (
      stp |-> o_step_up == ($past(o_target_mv) > $past(o_ref_mv)))
      else $error("step direction");
   up_c: cover property (o_step_up);
   down_c: cover property (o_step_down);
   shut_c: cover property ($rose(o_shutdown));
   retarget_c: cover property (o_busy && $changed(o_target_mv));
endmodule // vrs_checker
bind vrs_reference_stepper vrs_checker u_chk (.*);

// >>> tb/vrs_reference_stepper_tb_top.sv
// Self-checking bench for the reference stepper
`timescale 1ns/1ns
module vrs_reference_stepper_tb_top;
   logic i_mclk = 1'b0;
   logic i_rstn = 1'b0;
   logic i_cycle_start = 1'b0;
   logic [4:0] i_voltage_id_code, o_ref_index;
   logic [10:0] o_ref_mv, o_target_mv;
   logic o_busy, o_step_up, o_step_down, o_shutdown, o_done;
   int num_errors = 0;
   int n_compared = 0;
   int ph = 0;
   always #10 i_mclk = ~i_mclk;
   always @(negedge i_mclk)
   begin
      ph = (ph + 1) % 4;
      i_cycle_start <= (ph == 0);
   end
   vrs_cpu_model cpu (.i_mclk(i_mclk), .o_code(i_voltage_id_code));
   vrs_reference_stepper dut (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_cycle_start(i_cycle_start),
      .i_voltage_id_code(i_voltage_id_code),
      .o_ref_index(o_ref_index),
      .o_ref_mv(o_ref_mv),
      .o_target_mv(o_target_mv),
      .o_busy(o_busy),
      .o_step_up(o_step_up),
      .o_step_down(o_step_down),
      .o_shutdown(o_shutdown),
      .o_done(o_done)
   );
   task automatic chk(input logic [10:0] s, e);
      n_compared++;
      if (s !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %0t: %0h not %0h", $time, s, e);
      end
   endtask
   task automatic wrap_up;
      $display("compared %0d, mismatched %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic limit(input logic hung);
      if (hung)
      begin
         num_errors++;
         wrap_up();
      end
   endtask
   function automatic logic [10:0] mv(input logic [4:0] c);
      return 11'h60E - 11'h019 * c;
   endfunction
   task automatic go(input logic [4:0] c, f);
      int n, ns, nst;
      n = (c > f) ? c - f : f - c;
      ns = 0;
      nst = 0;
      @(posedge i_mclk iff i_cycle_start);
      cpu.put(c);
      while (!o_done)
      begin
         @(negedge i_mclk);
         nst += i_cycle_start;
         ns += (c > f) ? o_step_down : o_step_up;
         if (nst > 99)
         begin
            num_errors++;
            wrap_up();
         end
      end
      @(negedge i_mclk);
      chk(o_ref_mv, mv(c));
      chk(11'(o_ref_index), 11'(c));
      chk(o_target_mv, mv(c));
      chk(11'(ns), 11'(n));
      chk(11'(o_busy | o_shutdown), 11'h000);
      chk(11'(nst > 2 * n + 2 && nst <= 2 * n + 4), 11'h001);
   endtask
   task automatic t_ramp;
      go(5'h00, 5'h1E);
      go(5'h10, 5'h00);
      $display("ramps done");
   endtask
   task automatic t_shut;
      cpu.put(5'h1F);
      repeat (20) @(negedge i_mclk);
      chk(11'(o_shutdown), 11'h001);
      chk(o_target_mv, mv(5'h10));
      go(5'h0F, 5'h10);
      $display("shutdown done");
   endtask
   task automatic t_glitch;
      logic seen;
      seen = 1'b0;
      @(posedge i_mclk iff i_cycle_start);
      cpu.put(5'h00);
      cpu.put(5'h0F);
      @(posedge i_mclk iff i_cycle_start);
      cpu.put(5'h00);
      @(posedge i_mclk iff i_cycle_start);
      cpu.put(5'h0F);
      repeat (24)
      begin
         @(negedge i_mclk);
         seen |= o_busy;
      end
      chk(11'(seen), 11'h000);
      chk(o_target_mv, mv(5'h0F));
      $display("glitch done");
   endtask
   task automatic t_retarget;
      int k, ups, late_ups, downs;
      logic [4:0] at;
      ups = 0;
      late_ups = 0;
      downs = 0;
      cpu.put(5'h05);
      for (k = 0; k < 200 && ups < 2; k++)
      begin
         @(negedge i_mclk);
         ups += o_step_up;
      end
      limit(ups < 2);
      cpu.put(5'h14);
      for (k = 0; k < 200 && o_target_mv != mv(5'h14); k++)
         @(negedge i_mclk);
      limit(o_target_mv != mv(5'h14));
      at = o_ref_index;
      for (k = 0; k < 400 && !o_done; k++)
      begin
         @(negedge i_mclk);
         late_ups += o_step_up;
         downs += o_step_down;
      end
      limit(!o_done);
      @(negedge i_mclk);
      chk(11'(at > 5'h05 && at < 5'h0F), 11'h001);
      chk(11'(late_ups), 11'h000);
      chk(11'(downs), 11'(5'h14 - at));
      chk(o_ref_mv, mv(5'h14));
      chk(11'(o_busy), 11'h000);
      $display("retarget done");
   endtask
   initial
   begin
      repeat (10) @(negedge i_mclk);
      i_rstn <= 1'b1;
      @(negedge i_mclk);
      chk(o_ref_mv, 11'h320);
      chk(11'({o_shutdown, o_busy}), 11'h002);
      $display("reset done");
      t_ramp();
      t_shut();
      t_glitch();
      t_retarget();
      wrap_up();
   end
endmodule // vrs_reference_stepper_tb_top
